// ---- src/msdc_dwell_ctrl.sv ----
// Motion output dwell controller: time base, settings, dwell state machine, APB
`timescale 1ns/1ns

// Function
// - Decode sensor serial frames into detections; switch logic and relay outputs on.
// - Ten selectable dwell durations from 200 ms to ten minutes.
// - Unprogrammed dwell is one second.
// - Five sensitivity levels, medium when unprogrammed.
// - Retriggerable mode restarts dwell timer on each new detection.
// - Shortest dwell never retriggers, even in retriggerable mode.
// - Single event mode gives exactly one dwell period, not extended.
// - Single event mode waits for about one second of quiet, longer at high sensitivity.
// - Logic output low without motion, high during motion and dwell.
// - Relay driver conducts to ground only during motion and dwell.
// - Store strobe held low one second then released commits the selection.
// - Restore selection plus store returns all settings to defaults.
module msdc_dwell_ctrl
   import msdc_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES,
   parameter int BIT_CYCLES_P  = SENSOR_BIT_CYCLES
) (
   input  wire logic        CLOCK,
   input  wire logic        RESET,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        SENSOR_DATA,
   input  wire logic        STORE_STROBE_N,
   input  wire logic        SELECT_INPUT_A_N,
   input  wire logic        SELECT_INPUT_B_N,
   input  wire logic [2:0]  SELECT_RESISTOR_INPUT,
   output logic             LOGIC_OUT,
   output logic             RELAY_DRIVE
);
   localparam int TW = $clog2(TICK_CYCLES_P);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [TW-1:0]    tick_div_q;
   logic             tick_q;
   logic             motion;
   msdc_prog_type    prog;
   msdc_setting_type set_q;
   msdc_state_type   state_q;
   logic [19:0]      dwell_cnt_q;
   logic [11:0]      quiet_cnt_q;
   logic [31:0]      detect_cnt_q;
   logic             retrig_ok;
   logic             dwell_done;
   logic             quiet_done;
   logic [11:0]      quiet_limit;
   logic             apb_setup;
   logic             apb_write;
   logic [31:0]      ctrl_view;
   logic [31:0]      status_view;

   function automatic logic reg_mapped(input logic [11:0] addr);
      reg_mapped = (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET) || (addr == COUNT_OFFSET);
   endfunction

   // ----------------------------------------------------------------------
   // Time base
   // ----------------------------------------------------------------------
   // one millisecond tick
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         tick_div_q <= '0;
         tick_q     <= 1'b0;
      end else begin
         tick_q <= (tick_div_q == TW'(TICK_CYCLES_P - 1));
         if (tick_div_q == TW'(TICK_CYCLES_P - 1))
            tick_div_q <= '0;
         else
            tick_div_q <= tick_div_q + TW'(1);
      end
   end

   // ----------------------------------------------------------------------
   // Sensor and programming pins
   // ----------------------------------------------------------------------
   msdc_sensor_rx #(
      .BIT_CYCLES (BIT_CYCLES_P)
   ) u_rx (
      .clk      (CLOCK),
      .rst      (RESET),
      .data_pin (SENSOR_DATA),
      .sens     (set_q.sens),
      .motion   (motion)
   );

   msdc_prog_pins u_prog (
      .clk                   (CLOCK),
      .rst                   (RESET),
      .tick                  (tick_q),
      .store_strobe_n        (STORE_STROBE_N),
      .select_input_a_n      (SELECT_INPUT_A_N),
      .select_input_b_n      (SELECT_INPUT_B_N),
      .select_resistor_input (SELECT_RESISTOR_INPUT),
      .prog                  (prog)
   );

   // ----------------------------------------------------------------------
   // Settings
   // ----------------------------------------------------------------------
   assign apb_setup = PSEL && !PENABLE;
   assign apb_write = PSEL && PENABLE && PREADY && PWRITE;

   // defaults at reset; a pin store overrides a same-cycle bus write
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         set_q <= SETTING_DEFAULT;
      end else begin
         if (apb_write && PADDR == CTRL_OFFSET) begin
            // Out of range codes are ignored so the settings stay legal
            if (PWDATA[CTRL_SENS_LSB +: 3] <= SENS_MAX)
               set_q.sens <= PWDATA[CTRL_SENS_LSB +: 3];
            if (PWDATA[CTRL_DWELL_LSB +: 4] <= DWELL_MAX)
               set_q.dwell <= PWDATA[CTRL_DWELL_LSB +: 4];
            set_q.mode <= msdc_mode_type'(PWDATA[CTRL_MODE_BIT]);
         end
         if (prog.sens_wr)
            set_q.sens <= prog.val.sens;
         if (prog.dwell_wr)
            set_q.dwell <= prog.val.dwell;
         if (prog.mode_wr)
            set_q.mode <= prog.val.mode;
         if (prog.restore)
            set_q <= SETTING_DEFAULT;
      end
   end

   // ----------------------------------------------------------------------
   // Dwell state machine
   // ----------------------------------------------------------------------
   // shortest dwell is never retriggered
   assign retrig_ok   = (set_q.mode == MSDC_MODE_RETRIG) && (set_q.dwell != DWELL_SHORTEST);
   // Compare with >= so a shorter dwell written mid-period still ends on the next tick
   assign dwell_done  = tick_q && (dwell_cnt_q >= dwell_ms(set_q.dwell) - 20'h00001);
   assign quiet_limit = 12'(QUIET_BASE_MS) + 12'(QUIET_STEP_MS) * {9'h000, set_q.sens};
   assign quiet_done  = tick_q && (quiet_cnt_q >= quiet_limit - 12'h001);

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         state_q     <= MSDC_IDLE;
         dwell_cnt_q <= '0;
         quiet_cnt_q <= '0;
      end else begin
         unique case (state_q)
            MSDC_IDLE: begin
               if (motion) begin
                  state_q     <= MSDC_ON;
                  dwell_cnt_q <= '0;
               end
            end
            MSDC_ON: begin
               if (motion && retrig_ok) begin
                  dwell_cnt_q <= '0;
               end else if (dwell_done) begin
                  // single mode ends after one period
                  dwell_cnt_q <= '0;
                  quiet_cnt_q <= '0;
                  state_q     <= (set_q.mode == MSDC_MODE_SINGLE) ? MSDC_HOLDOFF : MSDC_IDLE;
               end else if (tick_q) begin
                  dwell_cnt_q <= dwell_cnt_q + 20'h00001;
               end
            end
            MSDC_HOLDOFF: begin
               // any motion restarts the quiet wait
               if (motion)
                  quiet_cnt_q <= '0;
               else if (quiet_done)
                  state_q <= MSDC_IDLE;
               else if (tick_q)
                  quiet_cnt_q <= quiet_cnt_q + 12'h001;
            end
            default: begin
               state_q <= MSDC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Outputs follow the next state so they track the machine with no lag
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         LOGIC_OUT   <= 1'b0;
         RELAY_DRIVE <= 1'b0;
      end else begin
         LOGIC_OUT   <= (state_q == MSDC_ON && !(dwell_done && !(motion && retrig_ok)))
                        || (state_q == MSDC_IDLE && motion);
         RELAY_DRIVE <= (state_q == MSDC_ON && !(dwell_done && !(motion && retrig_ok)))
                        || (state_q == MSDC_IDLE && motion);
      end
   end

   // Detection counter, cleared by a bus write to its own register; a same-cycle detection counts as one after the clear
   always_ff @(posedge CLOCK) begin
      if (RESET)
         detect_cnt_q <= '0;
      else if (motion)
         detect_cnt_q <= (apb_write && PADDR == COUNT_OFFSET) ? 32'h00000001
                                                              : detect_cnt_q + 32'h00000001;
      else if (apb_write && PADDR == COUNT_OFFSET)
         detect_cnt_q <= '0;
   end

   // ----------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------
   always_comb begin
      ctrl_view                        = '0;
      ctrl_view[CTRL_SENS_LSB +: 3]    = set_q.sens;
      ctrl_view[CTRL_DWELL_LSB +: 4]   = set_q.dwell;
      ctrl_view[CTRL_MODE_BIT]         = set_q.mode;
      status_view                      = '0;
      status_view[STATUS_ON_BIT]       = LOGIC_OUT;
      status_view[STATUS_STATE_LSB +: 3] = state_q;
      status_view[STATUS_CNT_LSB +: 20]  = dwell_cnt_q;
   end

   // Zero wait states: read data and error are prepared in the setup cycle
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         PRDATA  <= '0;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= 1'b1;
         if (apb_setup) begin
            PSLVERR <= !reg_mapped(PADDR);
            if (PWRITE || !reg_mapped(PADDR))
               PRDATA <= '0;
            else if (PADDR == CTRL_OFFSET)
               PRDATA <= ctrl_view;
            else if (PADDR == STATUS_OFFSET)
               PRDATA <= status_view;
            else
               PRDATA <= detect_cnt_q;
         end
      end
   end
endmodule

// ---- inc/msdc_pkg.sv ----
// Shared constants and types for the motion output dwell control block
package msdc_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 20;
   localparam int TICK_PERIOD_NS  = 1_000_000;
   localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int STORE_HOLD_MS   = 1000;
   localparam int STORE_HOLD_TICKS = STORE_HOLD_MS * 1_000_000 / TICK_PERIOD_NS;
   localparam int QUIET_BASE_MS   = 1000;
   localparam int QUIET_STEP_MS   = 250;
   localparam int SENSOR_BIT_CYCLES = 50;
   localparam int SENSOR_BITS     = 8;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [11:0] COUNT_OFFSET  = 12'h008;
   localparam int CTRL_SENS_LSB   = 0;
   localparam int CTRL_DWELL_LSB  = 4;
   localparam int CTRL_MODE_BIT   = 8;
   localparam int STATUS_ON_BIT   = 0;
   localparam int STATUS_STATE_LSB = 1;
   localparam int STATUS_CNT_LSB  = 4;

   // ----------------------------------------------------------------------
   // Settings and their defaults
   // ----------------------------------------------------------------------
   typedef enum logic {
      MSDC_MODE_RETRIG = 1'b0,
      MSDC_MODE_SINGLE = 1'b1
   } msdc_mode_type;

   localparam logic [2:0] SENS_DEFAULT   = 3'h2;
   localparam logic [2:0] SENS_MAX       = 3'h4;
   localparam logic [3:0] DWELL_DEFAULT  = 4'h1;
   localparam logic [3:0] DWELL_SHORTEST = 4'h0;
   localparam logic [3:0] DWELL_MAX      = 4'h9;

   typedef struct packed {
      logic [2:0]    sens;
      logic [3:0]    dwell;
      msdc_mode_type mode;
   } msdc_setting_type;

   localparam msdc_setting_type SETTING_DEFAULT = '{SENS_DEFAULT, DWELL_DEFAULT, MSDC_MODE_RETRIG};

   typedef struct packed {
      logic             sens_wr;
      logic             dwell_wr;
      logic             mode_wr;
      logic             restore;
      msdc_setting_type val;
   } msdc_prog_type;

   // Resistor ladder codes on the select resistor input
   localparam logic [2:0] RES_GND = 3'h0;
   localparam logic [2:0] RES_2K7 = 3'h1;
   localparam logic [2:0] RES_6K8 = 3'h2;
   localparam logic [2:0] RES_15K = 3'h3;
   localparam logic [2:0] RES_39K = 3'h4;

   typedef enum logic [2:0] {
      MSDC_IDLE    = 3'b001,
      MSDC_ON      = 3'b010,
      MSDC_HOLDOFF = 3'b100
   } msdc_state_type;

   // Dwell length in time-base ticks (milliseconds)
   function automatic logic [19:0] dwell_ms(input logic [3:0] code);
      case (code)
         4'h0:    dwell_ms = 20'h000c8;
         4'h1:    dwell_ms = 20'h003e8;
         4'h2:    dwell_ms = 20'h007d0;
         4'h3:    dwell_ms = 20'h01388;
         4'h4:    dwell_ms = 20'h02710;
         4'h5:    dwell_ms = 20'h07530;
         4'h6:    dwell_ms = 20'h0ea60;
         4'h7:    dwell_ms = 20'h1d4c0;
         4'h8:    dwell_ms = 20'h493e0;
         default: dwell_ms = 20'h927c0;
      endcase
   endfunction

   // Amplitude threshold; higher sensitivity means a lower threshold
   function automatic logic [7:0] sens_threshold(input logic [2:0] sens);
      case (sens)
         3'h0:    sens_threshold = 8'h60;
         3'h1:    sens_threshold = 8'h40;
         3'h2:    sens_threshold = 8'h28;
         3'h3:    sens_threshold = 8'h18;
         default: sens_threshold = 8'h0c;
      endcase
   endfunction

endpackage

// ---- src/msdc_sensor_rx.sv ----
// Serial infrared sensor frame receiver and motion decision
`timescale 1ns/1ns
module msdc_sensor_rx
   import msdc_pkg::*;
#(
   parameter int BIT_CYCLES = SENSOR_BIT_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       data_pin,
   input  wire logic [2:0] sens,
   output logic            motion
);
   localparam int DW = $clog2(2 * BIT_CYCLES);

   logic          sync0_q, sync1_q, prev_q;
   logic          busy_q;
   logic [DW-1:0] div_q;
   logic [3:0]    bit_q;
   logic [7:0]    shift_q;
   logic [7:0]    byte_d;
   logic [7:0]    mag_d;

   always_ff @(posedge clk) begin
      if (rst) begin
         sync0_q <= 1'b0;
         sync1_q <= 1'b0;
         prev_q  <= 1'b0;
      end else begin
         sync0_q <= data_pin;
         sync1_q <= sync0_q;
         prev_q  <= sync1_q;
      end
   end

   assign byte_d = {shift_q[6:0], sync1_q};
   assign mag_d  = byte_d[7] ? 8'(-byte_d) : byte_d;

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_q  <= 1'b0;
         div_q   <= '0;
         bit_q   <= '0;
         shift_q <= '0;
         motion  <= 1'b0;
      end else begin
         motion <= 1'b0;
         if (!busy_q) begin
            // Rising edge is the start bit; first sample lands mid data bit
            if (sync1_q && !prev_q) begin
               busy_q <= 1'b1;
               div_q  <= DW'(BIT_CYCLES + BIT_CYCLES / 2 - 1);
               bit_q  <= '0;
            end
         end else if (div_q == '0) begin
            shift_q <= byte_d;
            div_q   <= DW'(BIT_CYCLES - 1);
            bit_q   <= bit_q + 4'h1;
            if (bit_q == 4'(SENSOR_BITS - 1)) begin
               busy_q <= 1'b0;
               motion <= (mag_d > sens_threshold(sens));
            end
         end else begin
            div_q <= div_q - DW'(1);
         end
      end
   end
endmodule

// ---- src/msdc_prog_pins.sv ----
// Programming pin sampler: hold-and-release store with setting decode
`timescale 1ns/1ns
module msdc_prog_pins
   import msdc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       tick,
   input  wire logic       store_strobe_n,
   input  wire logic       select_input_a_n,
   input  wire logic       select_input_b_n,
   input  wire logic [2:0] select_resistor_input,
   output msdc_prog_type   prog
);
   localparam int HW = $clog2(STORE_HOLD_TICKS + 1);

   logic [5:0]    sync0_q, sync1_q;
   logic [HW-1:0] hold_q;
   msdc_prog_type dec_d;

   always_ff @(posedge clk) begin
      if (rst) begin
         sync0_q <= 6'h3f;
         sync1_q <= 6'h3f;
      end else begin
         sync0_q <= {store_strobe_n, select_input_a_n, select_input_b_n, select_resistor_input};
         sync1_q <= sync0_q;
      end
   end

   // Grounded pin reads as zero
   always_comb begin
      dec_d     = '0;
      dec_d.val = SETTING_DEFAULT;
      unique case ({sync1_q[4], sync1_q[3]})
         2'b11: begin
            dec_d.sens_wr = (sync1_q[2:0] <= RES_39K);
            unique case (sync1_q[2:0])
               RES_2K7: dec_d.val.sens = 3'h0;
               RES_6K8: dec_d.val.sens = 3'h1;
               RES_15K: dec_d.val.sens = 3'h3;
               RES_39K: dec_d.val.sens = 3'h4;
               default: dec_d.val.sens = SENS_DEFAULT;
            endcase
         end
         2'b01, 2'b10: begin
            dec_d.dwell_wr = (sync1_q[2:0] <= RES_39K);
            unique case (sync1_q[2:0])
               RES_GND: dec_d.val.dwell = sync1_q[4] ? 4'h5 : 4'h1;
               RES_2K7: dec_d.val.dwell = sync1_q[4] ? 4'h6 : 4'h0;
               RES_6K8: dec_d.val.dwell = sync1_q[4] ? 4'h7 : 4'h2;
               RES_15K: dec_d.val.dwell = sync1_q[4] ? 4'h8 : 4'h3;
               default: dec_d.val.dwell = sync1_q[4] ? 4'h9 : 4'h4;
            endcase
         end
         default: begin
            dec_d.restore = (sync1_q[2:0] == RES_GND);
            dec_d.mode_wr = (sync1_q[2:0] == RES_2K7) || (sync1_q[2:0] == RES_6K8);
            dec_d.val.mode = (sync1_q[2:0] == RES_6K8) ? MSDC_MODE_SINGLE : MSDC_MODE_RETRIG;
         end
      endcase
   end

   // commit after one second of grounded store strobe, on release
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_q <= '0;
         prog   <= '0;
      end else begin
         prog <= '0;
         if (!sync1_q[5]) begin
            if (tick && hold_q != HW'(STORE_HOLD_TICKS))
               hold_q <= hold_q + HW'(1);
         end else begin
            if (hold_q == HW'(STORE_HOLD_TICKS))
               prog <= dec_d;
            hold_q <= '0;
         end
      end
   end
endmodule

// ---- verification/msdc_load_model.sv ----
// Load model: relay coil or lamp pulled up to the supply on the relay driver
`timescale 1ns/1ns
module msdc_load_model (
   input  wire logic   clk,
   input  wire logic   relay_drive,
   output logic        node_level,
   output logic [31:0] on_cycles
);
   logic drive_q = 1'b0;

   // sinks only while driven
   // Released, the node floats up through the load, never keeps the low level
   assign node_level = relay_drive ? 1'b0 : 1'b1;

   always_ff @(posedge clk) begin
      drive_q <= relay_drive;
   end

   always_ff @(posedge clk) begin
      if (relay_drive && !drive_q) begin
         on_cycles <= 32'h1;
      end else if (relay_drive) begin
         on_cycles <= on_cycles + 32'h1;
      end
   end
endmodule

// ---- verification/msdc_dwell_asserts.sv ----
// Port checker for the dwell controller
`timescale 1ns/1ns
module msdc_dwell_asserts
   import msdc_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input wire logic        CLOCK,
   input wire logic        RESET,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        LOGIC_OUT,
   input wire logic        RELAY_DRIVE
);
   // One tick of slack either side of the shortest and longest dwell
   localparam int MIN_ON = 199 * TICK_CYCLES_P;
   // Ten minutes at the full clock rate needs more than 32 bits
   localparam longint MAX_ON = longint'(600001) * TICK_CYCLES_P;
   logic [39:0] on_cnt_q;
   logic        rd_status;
   logic        access;

   assign access = PSEL && PENABLE;
   assign rd_status = access && !PWRITE && (PADDR == STATUS_OFFSET);

   always_ff @(posedge CLOCK) begin
      if (RESET || !LOGIC_OUT) begin
         on_cnt_q <= 40'h0;
      end else begin
         on_cnt_q <= on_cnt_q + 40'h1;
      end
   end

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RESET);

   chk_relay_follows: assert property (RELAY_DRIVE == LOGIC_OUT)
      else $error("relay drive differs from logic output");
   chk_reset_quiet: assert property ($fell(RESET) |-> !LOGIC_OUT && !RELAY_DRIVE)
      else $error("outputs not off after reset");
   chk_dwell_floor: assert property ($fell(LOGIC_OUT) |-> on_cnt_q >= MIN_ON)
      else $error("output on shorter than the shortest dwell");
   chk_dwell_cap: assert property (LOGIC_OUT |-> on_cnt_q <= MAX_ON)
      else $error("output on longer than the longest dwell");
   chk_on_stretch: assert property ($rose(LOGIC_OUT) |=> LOGIC_OUT [*8])
      else $error("output dropped right after switching on");
   chk_status_mirror: assert property (rd_status |-> PRDATA[0] == $past(LOGIC_OUT))
      else $error("status on bit differs from logic output");
   chk_state_onehot: assert property (rd_status |-> $onehot(PRDATA[3:1]))
      else $error("status state field not one-hot");
   chk_unmapped_err: assert property (access |-> PSLVERR == !(PADDR inside {12'h0, 12'h4, 12'h8}))
      else $error("slave error flag wrong for address");
   chk_unmapped_zero: assert property (access && PSLVERR |-> PRDATA == 32'h0)
      else $error("read data not zero on slave error");
endmodule

bind msdc_dwell_ctrl msdc_dwell_asserts #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_asserts (
   .CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .LOGIC_OUT(LOGIC_OUT), .RELAY_DRIVE(RELAY_DRIVE)
);

// ---- verification/testbench.sv ----
// Self-checking bench for the motion output dwell controller
`timescale 1ns/1ns
module testbench;
   import msdc_pkg::*;
   // Short time base keeps the one-second holds affordable
   localparam int TICK = 20;
   logic        clock;
   logic        reset;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sensor_data;
   logic        store_n;
   logic        sel_a_n;
   logic        sel_b_n;
   logic [2:0]  sel_res;
   logic        logic_out;
   logic        relay_drive;
   logic        node_level;
   logic [31:0] on_cycles;
   logic [31:0] rd;
   logic        er;
   int          err_count;
   int          tests_run;

   msdc_dwell_ctrl #(.TICK_CYCLES_P(TICK), .BIT_CYCLES_P(4)) DUT (
      .CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SENSOR_DATA(sensor_data), .STORE_STROBE_N(store_n), .SELECT_INPUT_A_N(sel_a_n),
      .SELECT_INPUT_B_N(sel_b_n), .SELECT_RESISTOR_INPUT(sel_res),
      .LOGIC_OUT(logic_out), .RELAY_DRIVE(relay_drive)
   );
   msdc_load_model u_load (
      .clk(clock), .relay_drive(relay_drive), .node_level(node_level), .on_cycles(on_cycles)
   );

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic close_out();
      if (err_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask

   // Widths are allowed three ticks for sync and tick phase
   task automatic chk_near(input logic [31:0] got, input int exp);
      tests_run++;
      if ($isunknown(got) || got < exp - 60 || got > exp + 60) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         err_count++;
         close_out();
      end
   endtask

   task automatic wait_out(input logic v, input int lim);
      int n;
      n = 0;
      while (logic_out !== v && n < lim) begin
         @(posedge clock);
         n++;
      end
      if (n >= lim) begin
         err_count++;
         close_out();
      end
   endtask

   // Start bit, eight amplitude bits MSB first, then the line returns low
   task automatic send_frame(input logic [7:0] amp);
      sensor_data <= 1'b1;
      repeat (4) @(posedge clock);
      for (int i = 7; i >= 0; i--) begin
         sensor_data <= amp[i];
         repeat (4) @(posedge clock);
      end
      sensor_data <= 1'b0;
      repeat (8) @(posedge clock);
   endtask

   task automatic store_pins(input logic a_n, input logic b_n, input logic [2:0] res);
      sel_a_n <= a_n;
      sel_b_n <= b_n;
      sel_res <= res;
      store_n <= 1'b0;
      repeat (STORE_HOLD_TICKS * TICK + 100) @(posedge clock);
      store_n <= 1'b1;
      repeat (10) @(posedge clock);
      sel_a_n <= 1'b1;
      sel_b_n <= 1'b1;
      sel_res <= 3'h7;
   endtask

   // ----------------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------------
   initial begin
      err_count = 0;
      tests_run = 0;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sensor_data = 1'b0;
      store_n = 1'b1;
      sel_a_n = 1'b1;
      sel_b_n = 1'b1;
      sel_res = 3'h7;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      repeat (2) @(posedge clock);
      apb(CTRL_OFFSET, 1'b0, 32'h0);
      chk(rd, 32'h12);
      apb(STATUS_OFFSET, 1'b0, 32'h0);
      chk(rd[3:0], 32'h2);
      apb(12'h010, 1'b0, 32'h0);
      chk(er, 32'h1);
      chk(rd, 32'h0);
      apb(CTRL_OFFSET, 1'b1, 32'h15);
      apb(CTRL_OFFSET, 1'b0, 32'h0);
      chk(rd, 32'h12);
      send_frame(8'h10);
      repeat (20) @(posedge clock);
      chk(logic_out, 32'h0);
      apb(CTRL_OFFSET, 1'b1, 32'h2);
      send_frame(8'h7f);
      wait_out(1'b1, 100);
      chk({relay_drive, node_level}, 32'h2);
      repeat (1000) @(posedge clock);
      send_frame(8'h7f);
      wait_out(1'b0, 10000);
      chk_near(on_cycles, 200 * TICK);
      chk({relay_drive, node_level}, 32'h1);
      apb(CTRL_OFFSET, 1'b1, 32'h12);
      send_frame(8'h7f);
      wait_out(1'b1, 100);
      repeat (1000) @(posedge clock);
      send_frame(8'h81);
      wait_out(1'b0, 40000);
      chk_near(on_cycles, 1040 + 1000 * TICK);
      apb(CTRL_OFFSET, 1'b1, 32'h110);
      send_frame(8'h7f);
      wait_out(1'b1, 100);
      repeat (1000) @(posedge clock);
      send_frame(8'h7f);
      wait_out(1'b0, 30000);
      chk_near(on_cycles, 1000 * TICK);
      send_frame(8'h7f);
      repeat (100) @(posedge clock);
      chk(logic_out, 32'h0);
      apb(STATUS_OFFSET, 1'b0, 32'h0);
      chk(rd[3:0], 32'h8);
      apb(COUNT_OFFSET, 1'b0, 32'h0);
      chk(rd, 32'h7);
      apb(COUNT_OFFSET, 1'b1, 32'h0);
      apb(COUNT_OFFSET, 1'b0, 32'h0);
      chk(rd, 32'h0);
      store_pins(1'b0, 1'b1, RES_6K8);
      apb(CTRL_OFFSET, 1'b0, 32'h0);
      chk(rd, 32'h120);
      store_pins(1'b0, 1'b0, RES_GND);
      apb(CTRL_OFFSET, 1'b0, 32'h0);
      chk(rd, 32'h12);
      close_out();
   end
endmodule
